/* File: rtl/ecse_pin_sync.sv */
`timescale 1ns/1ps

// Wake pin synchroniser: three flops, a level change is accepted once
// the second and third stage agree, then one-cycle edge pulses.
module ecse_pin_sync (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic srst,
   // Pin
   input  wire logic pin_in,
   // Edge events
   output logic      rise_pulse,
   output logic      fall_pulse
);

   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       s3;
      logic [1:0] fill;
      logic       level;
      logic       primed;
      logic       rise;
      logic       fall;
   } ecse_sync_s;

   ecse_sync_s st_reg;
   ecse_sync_s st_next;

   always_comb begin
      st_next      = st_reg;
      st_next.s1   = pin_in;
      st_next.s2   = st_reg.s1;
      st_next.s3   = st_reg.s2;
      st_next.rise = 1'b0;
      st_next.fall = 1'b0;
      // Stages hold real pin samples only after three edges; before that
      // the reset zeros would be taken as the idle level
      if (st_reg.fill != 2'h3) begin
         st_next.fill = st_reg.fill + 2'h1;
      end
      // First agreed level after reset is taken as idle, not as an edge
      if ((st_reg.fill == 2'h3) && (st_reg.s2 == st_reg.s3)) begin
         st_next.primed = 1'b1;
         st_next.level  = st_reg.s3;
         if (st_reg.primed && (st_reg.s3 != st_reg.level)) begin
            st_next.rise = st_reg.s3;
            st_next.fall = ~st_reg.s3;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rise_pulse = st_reg.rise;
   assign fall_pulse = st_reg.fall;

endmodule : ecse_pin_sync

/* File: rtl/ecse_pkg.sv */
package ecse_pkg;

   // Register offsets
   localparam logic [6:0] ADDR_SYS_EN    = 7'h04;
   localparam logic [6:0] ADDR_SUP_EN    = 7'h1c;
   localparam logic [6:0] ADDR_TRX_EN    = 7'h23;
   localparam logic [6:0] ADDR_WAKE_EN   = 7'h4c;
   localparam logic [6:0] ADDR_GLOBAL_ST = 7'h60;
   localparam logic [6:0] ADDR_SYS_ST    = 7'h61;
   localparam logic [6:0] ADDR_SUP_ST    = 7'h62;
   localparam logic [6:0] ADDR_TRX_ST    = 7'h63;
   localparam logic [6:0] ADDR_WAKE_ST   = 7'h64;

   // System status and enable fields
   localparam int SYS_PO_BIT   = 4;
   localparam int SYS_OTW_BIT  = 2;
   localparam int SYS_SPIF_BIT = 1;
   localparam int SYS_WDF_BIT  = 0;
   // Supply fields
   localparam int SUP_OVR_BIT  = 2;
   localparam int SUP_UND_BIT  = 1;
   localparam int SUP_CORE_BIT = 0;
   // Transceiver fields
   localparam int TRX_PNFD_BIT = 5;
   localparam int TRX_SIL_BIT  = 4;
   localparam int TRX_FAIL_BIT = 1;
   localparam int TRX_WAKE_BIT = 0;
   // Wake pin fields
   localparam int WAKE_RISE_BIT = 1;
   localparam int WAKE_FALL_BIT = 0;
   // Global summary fields
   localparam int GLB_WAKE_BIT = 3;
   localparam int GLB_TRX_BIT  = 2;
   localparam int GLB_SUP_BIT  = 1;
   localparam int GLB_SYS_BIT  = 0;

   // Implemented bits; everything else reads zero
   localparam logic [7:0] SYS_ST_MASK   = 8'h17;
   localparam logic [7:0] SYS_EN_MASK   = 8'h06;
   localparam logic [7:0] SUP_MASK_FULL = 8'h07;
   localparam logic [7:0] SUP_MASK_CORE = 8'h01;
   localparam logic [7:0] TRX_ST_MASK   = 8'h33;
   localparam logic [7:0] TRX_EN_MASK   = 8'h13;
   localparam logic [7:0] WAKE_MASK     = 8'h03;

   // Reset values
   localparam logic [7:0] EN_RESET      = 8'h00;
   localparam logic [7:0] ST_RESET      = 8'h00;
   localparam logic [7:0] RDATA_RESET   = 8'h00;

   // Mode control value that qualifies the core undervoltage CAN failure
   localparam logic [1:0] CAN_MODE_ACTIVE = 2'h1;

endpackage : ecse_pkg

/* File: rtl/ecse_top.sv */
`timescale 1ns/1ps

// Notes on behaviour
// - Core supply undervoltage sets supply status bit 0.
// - Sensor supply undervoltage sets supply status bit 1.
// - Sensor supply overvoltage sets supply status bit 2.
// - Without sensor supply, its bits read zero.
// - Frame detector error always sets transceiver bit 5.
// - Bus silence timeout sets transceiver status bit 4.
// - Mode 01 undervoltage or clamped transmit sets bit 1.
// - Wake-up while offline sets transceiver status bit 0.
// - Wake input rising edge sets wake bit 1.
// - Wake input falling edge sets wake bit 0.
// - System enable bit 2 gates overtemperature warning.
// - System enable bit 1 gates SPI failure; bit0 reserved.
// - Supply enable bit 0 gates core undervoltage.
// - Supply enable bits 1,2 gate sensor events.
// - Transceiver enable bit 4 gates bus silence.
// - Transceiver enable bits 1,0 gate failure, wake.
// - Wake enable bits 1,0 gate rise, fall.
// - Flags set only when enabled; some always captured.
// - Writing 1 clears a flag; 0 keeps it.
// - Offline with core supply: pending events pull receive low.
// - Global summary shows one pending bit per group.
module ecse_top #(
   parameter bit HAS_SENSOR_SUPPLY = 1'b1
) (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       srst,
   // Register port
   input  wire logic [6:0] reg_addr,
   input  wire logic       reg_wr_en,
   input  wire logic       reg_rd_en,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic            reg_rvalid,
   // System event sources
   input  wire logic       power_on_evt,
   input  wire logic       watchdog_fail_evt,
   input  wire logic       overtemp_warn_evt,
   input  wire logic       spi_fail_evt,
   // Supply event sources
   input  wire logic       core_undervolt_evt,
   input  wire logic       sensor_undervolt_evt,
   input  wire logic       sensor_overvolt_evt,
   // Transceiver event sources and state
   input  wire logic       pn_frame_err_evt,
   input  wire logic       bus_silence_evt,
   input  wire logic [1:0] can_mode_control,
   input  wire logic       trx_core_uv_off,
   input  wire logic       txd_clamped,
   input  wire logic       can_wake_evt,
   input  wire logic       trx_offline,
   input  wire logic       core_supply_active,
   // Wake pin
   input  wire logic       wake_pin,
   // Receive line indication
   output logic            rxd_force_low
);

   typedef struct packed {
      logic [7:0] sys_en;
      logic [7:0] sup_en;
      logic [7:0] trx_en;
      logic [7:0] wake_en;
      logic [7:0] sys_st;
      logic [7:0] sup_st;
      logic [7:0] trx_st;
      logic [7:0] wake_st;
      logic       fail_cond_prev;
      logic [7:0] rdata;
      logic       rvalid;
      logic       rxd_low;
   } ecse_state_s;

   ecse_state_s st_reg;
   ecse_state_s st_next;

   logic wake_rise;
   logic wake_fall;

   // Sensor supply bits only exist on variants that have the output
   localparam logic [7:0] SUP_MASK = HAS_SENSOR_SUPPLY ?
      ecse_pkg::SUP_MASK_FULL : ecse_pkg::SUP_MASK_CORE;

   ecse_pin_sync u_wake_sync (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .pin_in     (wake_pin),
      .rise_pulse (wake_rise),
      .fall_pulse (wake_fall)
   );

   // Write data aimed at one register, zero otherwise
   function automatic logic [7:0] wr_bits(input logic [6:0] addr);
      wr_bits = (reg_wr_en && (reg_addr == addr)) ? reg_wdata : 8'h00;
   endfunction : wr_bits

   function automatic logic wr_hit(input logic [6:0] addr);
      wr_hit = reg_wr_en && (reg_addr == addr);
   endfunction : wr_hit

   logic [7:0] sys_set;
   logic [7:0] sup_set;
   logic [7:0] trx_set;
   logic [7:0] wake_set;
   logic [7:0] global_st;
   logic       fail_cond;

   always_comb begin
      st_next = st_reg;

      // Failure captured on the onset of the condition, so a held
      // condition does not re-raise the flag right after a clear
      fail_cond = ((can_mode_control == ecse_pkg::CAN_MODE_ACTIVE)
                   && trx_core_uv_off) || txd_clamped;
      st_next.fail_cond_prev = fail_cond;

      sys_set = 8'h00;
      sys_set[ecse_pkg::SYS_PO_BIT]   = power_on_evt;
      sys_set[ecse_pkg::SYS_WDF_BIT]  = watchdog_fail_evt;
      sys_set[ecse_pkg::SYS_OTW_BIT]  = overtemp_warn_evt
         && st_reg.sys_en[ecse_pkg::SYS_OTW_BIT];
      sys_set[ecse_pkg::SYS_SPIF_BIT] = spi_fail_evt
         && st_reg.sys_en[ecse_pkg::SYS_SPIF_BIT];

      sup_set = 8'h00;
      sup_set[ecse_pkg::SUP_CORE_BIT] = core_undervolt_evt
         && st_reg.sup_en[ecse_pkg::SUP_CORE_BIT];
      sup_set[ecse_pkg::SUP_UND_BIT]  = sensor_undervolt_evt
         && st_reg.sup_en[ecse_pkg::SUP_UND_BIT];
      sup_set[ecse_pkg::SUP_OVR_BIT]  = sensor_overvolt_evt
         && st_reg.sup_en[ecse_pkg::SUP_OVR_BIT];
      sup_set = sup_set & SUP_MASK;

      trx_set = 8'h00;
      trx_set[ecse_pkg::TRX_PNFD_BIT] = pn_frame_err_evt;
      trx_set[ecse_pkg::TRX_SIL_BIT]  = bus_silence_evt
         && st_reg.trx_en[ecse_pkg::TRX_SIL_BIT];
      trx_set[ecse_pkg::TRX_FAIL_BIT] = fail_cond && !st_reg.fail_cond_prev
         && st_reg.trx_en[ecse_pkg::TRX_FAIL_BIT];
      trx_set[ecse_pkg::TRX_WAKE_BIT] = can_wake_evt && trx_offline
         && st_reg.trx_en[ecse_pkg::TRX_WAKE_BIT];

      wake_set = 8'h00;
      wake_set[ecse_pkg::WAKE_RISE_BIT] = wake_rise
         && st_reg.wake_en[ecse_pkg::WAKE_RISE_BIT];
      wake_set[ecse_pkg::WAKE_FALL_BIT] = wake_fall
         && st_reg.wake_en[ecse_pkg::WAKE_FALL_BIT];

      // Set wins over a clear in the same cycle, so no event is lost
      st_next.sys_st  = ((st_reg.sys_st & ~wr_bits(ecse_pkg::ADDR_SYS_ST))
                         | sys_set) & ecse_pkg::SYS_ST_MASK;
      st_next.sup_st  = ((st_reg.sup_st & ~wr_bits(ecse_pkg::ADDR_SUP_ST))
                         | sup_set) & SUP_MASK;
      st_next.trx_st  = ((st_reg.trx_st & ~wr_bits(ecse_pkg::ADDR_TRX_ST))
                         | trx_set) & ecse_pkg::TRX_ST_MASK;
      st_next.wake_st = ((st_reg.wake_st
                          & ~wr_bits(ecse_pkg::ADDR_WAKE_ST))
                         | wake_set) & ecse_pkg::WAKE_MASK;

      if (wr_hit(ecse_pkg::ADDR_SYS_EN)) begin
         st_next.sys_en = reg_wdata & ecse_pkg::SYS_EN_MASK;
      end
      if (wr_hit(ecse_pkg::ADDR_SUP_EN)) begin
         st_next.sup_en = reg_wdata & SUP_MASK;
      end
      if (wr_hit(ecse_pkg::ADDR_TRX_EN)) begin
         st_next.trx_en = reg_wdata & ecse_pkg::TRX_EN_MASK;
      end
      if (wr_hit(ecse_pkg::ADDR_WAKE_EN)) begin
         st_next.wake_en = reg_wdata & ecse_pkg::WAKE_MASK;
      end

      global_st = 8'h00;
      global_st[ecse_pkg::GLB_SYS_BIT]  = |st_reg.sys_st;
      global_st[ecse_pkg::GLB_SUP_BIT]  = |st_reg.sup_st;
      global_st[ecse_pkg::GLB_TRX_BIT]  = |st_reg.trx_st;
      global_st[ecse_pkg::GLB_WAKE_BIT] = |st_reg.wake_st;

      st_next.rxd_low = trx_offline && core_supply_active
                        && (|global_st);

      // Reads return the value before any same-cycle write
      st_next.rvalid = reg_rd_en;
      st_next.rdata  = st_reg.rdata;
      if (reg_rd_en) begin
         case (reg_addr)
            ecse_pkg::ADDR_SYS_EN:    st_next.rdata = st_reg.sys_en;
            ecse_pkg::ADDR_SUP_EN:    st_next.rdata = st_reg.sup_en;
            ecse_pkg::ADDR_TRX_EN:    st_next.rdata = st_reg.trx_en;
            ecse_pkg::ADDR_WAKE_EN:   st_next.rdata = st_reg.wake_en;
            ecse_pkg::ADDR_GLOBAL_ST: st_next.rdata = global_st;
            ecse_pkg::ADDR_SYS_ST:    st_next.rdata = st_reg.sys_st;
            ecse_pkg::ADDR_SUP_ST:    st_next.rdata = st_reg.sup_st;
            ecse_pkg::ADDR_TRX_ST:    st_next.rdata = st_reg.trx_st;
            ecse_pkg::ADDR_WAKE_ST:   st_next.rdata = st_reg.wake_st;
            default:                  st_next.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_reg         <= '0;
         st_reg.sys_en  <= ecse_pkg::EN_RESET;
         st_reg.sup_en  <= ecse_pkg::EN_RESET;
         st_reg.trx_en  <= ecse_pkg::EN_RESET;
         st_reg.wake_en <= ecse_pkg::EN_RESET;
         st_reg.sys_st  <= ecse_pkg::ST_RESET;
         st_reg.sup_st  <= ecse_pkg::ST_RESET;
         st_reg.trx_st  <= ecse_pkg::ST_RESET;
         st_reg.wake_st <= ecse_pkg::ST_RESET;
         st_reg.rdata   <= ecse_pkg::RDATA_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata     = st_reg.rdata;
   assign reg_rvalid    = st_reg.rvalid;
   assign rxd_force_low = st_reg.rxd_low;

   default clocking ck @(posedge sys_clk); endclocking
   default disable iff (srst);

   sequence s_rd_global;
      reg_rd_en && (reg_addr == ecse_pkg::ADDR_GLOBAL_ST);
   endsequence

   sequence s_clear_core_uv;
      reg_wr_en && (reg_addr == ecse_pkg::ADDR_SUP_ST)
      && reg_wdata[ecse_pkg::SUP_CORE_BIT] && !core_undervolt_evt;
   endsequence

   chk_core_uv_set: assert property (
      core_undervolt_evt && st_reg.sup_en[ecse_pkg::SUP_CORE_BIT]
      |=> st_reg.sup_st[ecse_pkg::SUP_CORE_BIT])
      else $error("core undervolt flag not set");

   chk_core_uv_gate: assert property (
      $rose(st_reg.sup_st[ecse_pkg::SUP_CORE_BIT])
      |-> $past(core_undervolt_evt)
          && $past(st_reg.sup_en[ecse_pkg::SUP_CORE_BIT]))
      else $error("core undervolt flag set without enabled event");

   chk_sensor_absent: assert property (
      !HAS_SENSOR_SUPPLY |-> (st_reg.sup_st[2:1] == 2'h0)
                             && (st_reg.sup_en[2:1] == 2'h0))
      else $error("sensor supply bits active on variant without it");

   chk_sensor_ovr: assert property (
      sensor_overvolt_evt && st_reg.sup_en[ecse_pkg::SUP_OVR_BIT]
      |=> st_reg.sup_st[ecse_pkg::SUP_OVR_BIT])
      else $error("sensor overvolt flag not set");

   chk_pnfd_always: assert property (
      pn_frame_err_evt |=> st_reg.trx_st[ecse_pkg::TRX_PNFD_BIT])
      else $error("frame detector error not captured");

   chk_silence_gate: assert property (
      $rose(st_reg.trx_st[ecse_pkg::TRX_SIL_BIT])
      |-> $past(bus_silence_evt && st_reg.trx_en[ecse_pkg::TRX_SIL_BIT]))
      else $error("bus silence flag set without enabled event");

   chk_can_fail_set: assert property (
      txd_clamped && !$past(txd_clamped) && !st_reg.fail_cond_prev
      && st_reg.trx_en[ecse_pkg::TRX_FAIL_BIT]
      |=> st_reg.trx_st[ecse_pkg::TRX_FAIL_BIT])
      else $error("CAN failure flag not set on clamped transmit");

   chk_can_wake_offline: assert property (
      $rose(st_reg.trx_st[ecse_pkg::TRX_WAKE_BIT])
      |-> $past(can_wake_evt && trx_offline))
      else $error("CAN wake flag set outside offline mode");

   chk_wake_rise_set: assert property (
      wake_rise && st_reg.wake_en[ecse_pkg::WAKE_RISE_BIT]
      |=> st_reg.wake_st[ecse_pkg::WAKE_RISE_BIT])
      else $error("wake rise flag not set");

   chk_wake_fall_set: assert property (
      wake_fall && st_reg.wake_en[ecse_pkg::WAKE_FALL_BIT]
      |=> st_reg.wake_st[ecse_pkg::WAKE_FALL_BIT])
      else $error("wake fall flag not set");

   chk_otw_gate: assert property (
      $rose(st_reg.sys_st[ecse_pkg::SYS_OTW_BIT])
      |-> $past(st_reg.sys_en[ecse_pkg::SYS_OTW_BIT]))
      else $error("overtemp flag set while disabled");

   chk_spif_gate: assert property (
      $rose(st_reg.sys_st[ecse_pkg::SYS_SPIF_BIT])
      |-> $past(st_reg.sys_en[ecse_pkg::SYS_SPIF_BIT]))
      else $error("SPI failure flag set while disabled");

   chk_w1c_clear: assert property (
      s_clear_core_uv |=> !st_reg.sup_st[ecse_pkg::SUP_CORE_BIT])
      else $error("write one did not clear flag");

   chk_w0_keep: assert property (
      reg_wr_en && (reg_addr == ecse_pkg::ADDR_WAKE_ST)
      && !reg_wdata[ecse_pkg::WAKE_RISE_BIT]
      && st_reg.wake_st[ecse_pkg::WAKE_RISE_BIT]
      |=> st_reg.wake_st[ecse_pkg::WAKE_RISE_BIT])
      else $error("write zero disturbed flag");

   chk_rxd_pending: assert property (
      trx_offline && core_supply_active && (|st_reg.trx_st)
      |=> rxd_force_low)
      else $error("receive line not pulled low for pending event");

   chk_rxd_idle: assert property (
      !trx_offline |=> !rxd_force_low)
      else $error("receive line pulled low outside offline mode");

   chk_global_read: assert property (
      s_rd_global |=> reg_rvalid
         && (reg_rdata == {4'h0, $past(|st_reg.wake_st),
                           $past(|st_reg.trx_st), $past(|st_reg.sup_st),
                           $past(|st_reg.sys_st)}))
      else $error("global summary read wrong");

   chk_reserved_zero: assert property (
      ((st_reg.sys_en & ~ecse_pkg::SYS_EN_MASK) == 8'h00)
      && ((st_reg.trx_en & ~ecse_pkg::TRX_EN_MASK) == 8'h00)
      && ((st_reg.trx_st & ~ecse_pkg::TRX_ST_MASK) == 8'h00))
      else $error("reserved bit became set");

   chk_sensor_und: assert property (
      sensor_undervolt_evt && st_reg.sup_en[ecse_pkg::SUP_UND_BIT]
      |=> st_reg.sup_st[ecse_pkg::SUP_UND_BIT])
      else $error("sensor undervolt flag not set");

   chk_fail_gate: assert property (
      $rose(st_reg.trx_st[ecse_pkg::TRX_FAIL_BIT])
      |-> $past(st_reg.trx_en[ecse_pkg::TRX_FAIL_BIT]))
      else $error("CAN failure flag set while disabled");

   chk_wake_edge_gate: assert property (
      $rose(st_reg.wake_st[ecse_pkg::WAKE_RISE_BIT])
      |-> $past(wake_rise && st_reg.wake_en[ecse_pkg::WAKE_RISE_BIT]))
      else $error("wake rise flag set without enabled edge");

   chk_rxd_no_core: assert property (
      !core_supply_active |=> !rxd_force_low)
      else $error("receive line pulled low without core supply");

endmodule : ecse_top

/* File: tb/ecse_host_model.sv */
`timescale 1ns/1ps

// Host side of the register port. Strobes last one cycle; between
// requests the address and data are inverted so nothing stale is trusted.
module ecse_host_model (
   // Clock
   input  wire logic       sys_clk,
   // Register port
   output logic      [6:0] reg_addr,
   output logic            reg_wr_en,
   output logic            reg_rd_en,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   initial begin
      reg_addr  = 7'h7f;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_wdata = 8'h00;
   end

   // Status bits are cleared by writing 1 to them
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr  = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr_en = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask : wr

   // A missing valid pulse turns the data unknown so the compare fails
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr  = a;
      reg_rd_en = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_rd_en = 1'b0;
      reg_addr  = ~a;
      d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
   endtask : rd
endmodule : ecse_host_model

/* File: tb/tb_event_capture_status_enable.sv */
`timescale 1ns/1ps

module tb_event_capture_status_enable;
   logic       sys_clk;
   logic       srst;
   logic [6:0] reg_addr;
   logic       reg_wr_en;
   logic       reg_rd_en;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [7:0] ns_rdata;
   logic       reg_rvalid;
   // Event pulses: 0 po, 1 wdf, 2 otw, 3 spif, 4 core uv, 5 sens uv,
   // 6 sens ov, 7 frame err, 8 silence, 9 can wake
   logic [9:0] ev;
   logic [1:0] can_mode_control;
   logic       trx_core_uv_off;
   logic       txd_clamped;
   logic       trx_offline;
   logic       core_supply_active;
   logic       wake_pin;
   logic       rxd_force_low;
   logic [7:0] d;
   int         n_errors;
   int         cmp_count;
   int         cyc = 0;

   ecse_host_model host (
      .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   ecse_top uut (
      .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .power_on_evt(ev[0]), .watchdog_fail_evt(ev[1]),
      .overtemp_warn_evt(ev[2]), .spi_fail_evt(ev[3]),
      .core_undervolt_evt(ev[4]), .sensor_undervolt_evt(ev[5]),
      .sensor_overvolt_evt(ev[6]), .pn_frame_err_evt(ev[7]),
      .bus_silence_evt(ev[8]), .can_mode_control(can_mode_control),
      .trx_core_uv_off(trx_core_uv_off), .txd_clamped(txd_clamped),
      .can_wake_evt(ev[9]), .trx_offline(trx_offline),
      .core_supply_active(core_supply_active), .wake_pin(wake_pin),
      .rxd_force_low(rxd_force_low));

   // Variant without the sensor supply, sharing every input
   ecse_top #(.HAS_SENSOR_SUPPLY(1'b0)) uut_ns (
      .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
      .reg_rdata(ns_rdata), .reg_rvalid(),
      .power_on_evt(ev[0]), .watchdog_fail_evt(ev[1]),
      .overtemp_warn_evt(ev[2]), .spi_fail_evt(ev[3]),
      .core_undervolt_evt(ev[4]), .sensor_undervolt_evt(ev[5]),
      .sensor_overvolt_evt(ev[6]), .pn_frame_err_evt(ev[7]),
      .bus_silence_evt(ev[8]), .can_mode_control(can_mode_control),
      .trx_core_uv_off(trx_core_uv_off), .txd_clamped(txd_clamped),
      .can_wake_evt(ev[9]), .trx_offline(trx_offline),
      .core_supply_active(core_supply_active), .wake_pin(wake_pin),
      .rxd_force_low());

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic check(input string nm, input logic [7:0] got,
                        input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   task automatic rchk(input string nm, input logic [6:0] a,
                       input logic [7:0] exp);
      host.rd(a, d);
      check(nm, d, exp);
   endtask : rchk

   task automatic go(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : go

   task automatic pulse(input int i);
      go(1);
      ev[i] = 1'b1;
      go(1);
      ev[i] = 1'b0;
   endtask : pulse

   task automatic t_regs;
      rchk("sys_en rst", ecse_pkg::ADDR_SYS_EN, 8'h00);
      rchk("trx_st rst", ecse_pkg::ADDR_TRX_ST, 8'h00);
      host.wr(ecse_pkg::ADDR_SYS_EN, 8'hff);
      host.wr(ecse_pkg::ADDR_SUP_EN, 8'hff);
      host.wr(ecse_pkg::ADDR_TRX_EN, 8'hff);
      host.wr(ecse_pkg::ADDR_WAKE_EN, 8'hff);
      host.wr(ecse_pkg::ADDR_GLOBAL_ST, 8'hff);
      rchk("sys_en", ecse_pkg::ADDR_SYS_EN, 8'h06);
      rchk("sup_en", ecse_pkg::ADDR_SUP_EN, 8'h07);
      check("ns sup_en", ns_rdata, 8'h01);
      rchk("trx_en", ecse_pkg::ADDR_TRX_EN, 8'h13);
      rchk("wake_en", ecse_pkg::ADDR_WAKE_EN, 8'h03);
      rchk("global ro", ecse_pkg::ADDR_GLOBAL_ST, 8'h00);
      rchk("unmapped", 7'h7d, 8'h00);
      host.wr(ecse_pkg::ADDR_SYS_EN, 8'h00);
      host.wr(ecse_pkg::ADDR_SUP_EN, 8'h00);
      host.wr(ecse_pkg::ADDR_TRX_EN, 8'h00);
      host.wr(ecse_pkg::ADDR_WAKE_EN, 8'h00);
      $display("test regs done");
   endtask : t_regs

   task automatic t_system;
      for (int i = 0; i < 4; i++) pulse(i);
      rchk("sys gated", ecse_pkg::ADDR_SYS_ST, 8'h11);
      host.wr(ecse_pkg::ADDR_SYS_EN, 8'h06);
      pulse(2);
      pulse(3);
      rchk("sys all", ecse_pkg::ADDR_SYS_ST, 8'h17);
      rchk("global sys", ecse_pkg::ADDR_GLOBAL_ST, 8'h01);
      check("rxd online", {7'h00, rxd_force_low}, 8'h00);
      host.wr(ecse_pkg::ADDR_SYS_ST, 8'h17);
      rchk("sys clr", ecse_pkg::ADDR_SYS_ST, 8'h00);
      $display("test system done");
   endtask : t_system

   task automatic t_supply;
      for (int i = 4; i < 7; i++) pulse(i);
      rchk("sup gated", ecse_pkg::ADDR_SUP_ST, 8'h00);
      host.wr(ecse_pkg::ADDR_SUP_EN, 8'h07);
      for (int i = 4; i < 7; i++) pulse(i);
      rchk("sup set", ecse_pkg::ADDR_SUP_ST, 8'h07);
      check("ns sup_st", ns_rdata, 8'h01);
      rchk("global sup", ecse_pkg::ADDR_GLOBAL_ST, 8'h02);
      host.wr(ecse_pkg::ADDR_SUP_ST, 8'h00);
      rchk("sup w0", ecse_pkg::ADDR_SUP_ST, 8'h07);
      host.wr(ecse_pkg::ADDR_SUP_ST, 8'h02);
      rchk("sup w1", ecse_pkg::ADDR_SUP_ST, 8'h05);
      host.wr(ecse_pkg::ADDR_SUP_ST, 8'h05);
      rchk("sup clr", ecse_pkg::ADDR_SUP_ST, 8'h00);
      $display("test supply done");
   endtask : t_supply

   task automatic t_trx;
      // Failure onset and offline wake-up both dropped while disabled
      trx_offline = 1'b1;
      txd_clamped = 1'b1;
      pulse(9);
      txd_clamped = 1'b0;
      trx_offline = 1'b0;
      rchk("trx gated", ecse_pkg::ADDR_TRX_ST, 8'h00);
      pulse(7);
      pulse(8);
      rchk("trx frame", ecse_pkg::ADDR_TRX_ST, 8'h20);
      host.wr(ecse_pkg::ADDR_TRX_EN, 8'h13);
      pulse(8);
      can_mode_control = 2'h2;
      trx_core_uv_off = 1'b1;
      go(2);
      trx_core_uv_off = 1'b0;
      rchk("trx silence", ecse_pkg::ADDR_TRX_ST, 8'h30);
      can_mode_control = 2'h1;
      trx_core_uv_off = 1'b1;
      go(2);
      trx_core_uv_off = 1'b0;
      rchk("trx uv fail", ecse_pkg::ADDR_TRX_ST, 8'h32);
      host.wr(ecse_pkg::ADDR_TRX_ST, 8'h02);
      txd_clamped = 1'b1;
      go(2);
      txd_clamped = 1'b0;
      pulse(9);
      rchk("trx clamp", ecse_pkg::ADDR_TRX_ST, 8'h32);
      trx_offline = 1'b1;
      pulse(9);
      rchk("trx wake", ecse_pkg::ADDR_TRX_ST, 8'h33);
      rchk("global trx", ecse_pkg::ADDR_GLOBAL_ST, 8'h04);
      host.wr(ecse_pkg::ADDR_TRX_ST, 8'h33);
      rchk("trx clr", ecse_pkg::ADDR_TRX_ST, 8'h00);
      $display("test transceiver done");
   endtask : t_trx

   task automatic t_wake;
      wake_pin = 1'b1;
      go(8);
      wake_pin = 1'b0;
      go(8);
      rchk("wake gated", ecse_pkg::ADDR_WAKE_ST, 8'h00);
      host.wr(ecse_pkg::ADDR_WAKE_EN, 8'h03);
      wake_pin = 1'b1;
      go(8);
      rchk("wake rise", ecse_pkg::ADDR_WAKE_ST, 8'h02);
      check("rxd low", {7'h00, rxd_force_low}, 8'h01);
      wake_pin = 1'b0;
      go(8);
      rchk("wake fall", ecse_pkg::ADDR_WAKE_ST, 8'h03);
      core_supply_active = 1'b0;
      go(3);
      check("rxd no core", {7'h00, rxd_force_low}, 8'h00);
      core_supply_active = 1'b1;
      go(3);
      check("rxd back", {7'h00, rxd_force_low}, 8'h01);
      host.wr(ecse_pkg::ADDR_WAKE_ST, 8'h01);
      rchk("wake w0", ecse_pkg::ADDR_WAKE_ST, 8'h02);
      host.wr(ecse_pkg::ADDR_WAKE_ST, 8'h02);
      go(4);
      check("rxd clr", {7'h00, rxd_force_low}, 8'h00);
      rchk("wake clr", ecse_pkg::ADDR_WAKE_ST, 8'h00);
      $display("test wake done");
   endtask : t_wake

   initial begin
      n_errors = 0;
      cmp_count = 0;
      ev = '0;
      can_mode_control = 2'h0;
      trx_core_uv_off = 1'b0;
      txd_clamped = 1'b0;
      trx_offline = 1'b0;
      core_supply_active = 1'b1;
      wake_pin = 1'b0;
      srst = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      srst = 1'b0;
      // Wake synchroniser primes before any pin activity
      go(4);
      t_regs();
      t_system();
      t_supply();
      t_trx();
      t_wake();
      give_verdict();
   end
endmodule : tb_event_capture_status_enable
